// file: tt_tracer.sv
// tt_tracer: bus cycle tracer with trigger, qualification and trace memory
`timescale 1ns/1ps
`default_nettype none
module tt_tracer
  import tt_pkg::*;
#(
  parameter int NUM_TRIG = NUM_WORDS,
  parameter int NUM_QUAL = NUM_WORDS,
  parameter int DEPTH    = TRACE_DEPTH,
  localparam int PW      = $clog2(DEPTH),
  localparam int IW      = $clog2(NUM_WORDS)
)(
  // clock and reset
  input  wire logic                 sys_clk,
  input  wire logic                 rst_b,
  // observed bus cycle
  input  wire logic                 bus_valid,
  input  wire logic [DATA_W-1:0]    bus_data,
  input  wire logic [ADDR_W-1:0]    bus_addr_phys,
  input  wire logic [BANK_W-1:0]    bus_bank,
  input  wire logic [ADDR_W-1:0]    bus_addr_log,
  input  wire logic [TABLE_W-1:0]   bus_table_nr,
  input  wire logic [LEVEL_W-1:0]   bus_level,
  input  wire logic                 bus_io_transfer_cycle,
  input  wire logic                 bus_io_transfer_variant_cycle,
  input  wire logic                 bus_fetch,
  input  wire logic                 bus_write,
  input  wire logic                 bus_cpu,
  input  wire logic                 bus_alternate_page_table,
  input  wire logic                 bus_interrupts_enabled,
  input  wire logic                 bus_paging_enabled,
  input  wire logic                 cpu_stopped,
  // select word setup
  input  wire logic                 cfg_we,
  input  wire logic                 cfg_qual,
  input  wire logic [IW-1:0]        cfg_idx,
  input  wire logic [2:0]           cfg_field,
  input  wire logic [DATA_W-1:0]    cfg_val,
  input  wire logic [DATA_W-1:0]    cfg_care,
  input  wire logic [NUM_TRIG-1:0]  trig_word_en,
  input  wire logic [NUM_QUAL-1:0]  qual_word_en,
  // trace control
  input  wire logic                 trace_start,
  input  wire logic                 trace_abort,
  input  wire logic                 arm_mode,
  input  wire logic                 stop_on_trig,
  input  wire logic                 trig_on_stop,
  input  wire logic [PW-1:0]        trig_pos,
  // status
  output logic                      st_clearing,
  output logic                      st_wait_arm,
  output logic                      st_wait_trig,
  output logic                      st_post_trig,
  output logic                      st_trig_done,
  output logic                      st_aborted,
  output logic                      stop_req,
  output logic                      trig_seen,
  output logic [PW-1:0]             trig_addr,
  output logic [PW-1:0]             wr_ptr,
  // readout
  input  wire logic [PW-1:0]        rd_addr,
  output tt_entry_type              rd_data
);
  localparam logic [PW-1:0] POS_LAST = PW'(DEPTH - 1);
  localparam logic [PW-1:0] PTR_ONE  = PW'(1);

  tt_state_type state_reg;
  tt_state_type state_next;

  tt_sel_type   trig_sel_reg [NUM_TRIG];
  tt_sel_type   qual_sel_reg [NUM_QUAL];
  tt_entry_type trace_mem [DEPTH];

  tt_entry_type cyc_next;
  tt_entry_type cyc_reg;
  logic         cyc_valid_reg;

  logic [NUM_TRIG-1:0] trig_hit;
  logic [NUM_QUAL-1:0] qual_hit;
  logic                io_exec;
  logic                stopped_reg;
  logic                stop_rise;
  logic                trig_any;
  logic                qual_any;
  logic                arm_hit;
  logic                capturing;
  logic                qual_wr;
  logic                trig_fire;

  logic                arm_reg;
  logic                stop_on_trig_reg;
  logic                trig_on_stop_reg;
  logic [PW-1:0]       post_init_reg;
  logic [PW-1:0]       post_left_reg;
  logic [PW-1:0]       clr_ptr_reg;

  tt_cyc_if cyc_bus ();

  // setup port: one field of one select word per write
  function automatic tt_sel_type sel_update(input tt_sel_type s,
                                            input logic [2:0] f,
                                            input logic [DATA_W-1:0] v,
                                            input logic [DATA_W-1:0] c);
    tt_sel_type r;
    r = s;
    case (f)
      FLD_DATA: begin
        r.data_val  = v;
        r.data_care = c;
      end
      FLD_ADDR: begin
        r.addr_val  = v;
        r.addr_care = c;
      end
      FLD_BANK: begin
        r.bank_val  = v[BANK_W-1:0];
        r.bank_care = c[BANK_W-1:0];
      end
      FLD_CTRL: begin
        r.ctrl_val  = v[CTRL_W-1:0];
        r.ctrl_care = c[CTRL_W-1:0];
      end
      FLD_LEVEL: r.level_en = v[2**LEVEL_W-1:0];
      FLD_TABLE: r.table_en = v[2**TABLE_W-1:0];
      FLD_MODE:  r.logical  = v[0];
      default:   r = s;
    endcase
    return r;
  endfunction

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < NUM_TRIG; i++) begin
        trig_sel_reg[i] <= '0;
      end
      for (int i = 0; i < NUM_QUAL; i++) begin
        qual_sel_reg[i] <= '0;
      end
    end else if (cfg_we) begin
      if (cfg_qual) begin
        qual_sel_reg[cfg_idx] <= sel_update(qual_sel_reg[cfg_idx], cfg_field, cfg_val, cfg_care);
      end else begin
        trig_sel_reg[cfg_idx] <= sel_update(trig_sel_reg[cfg_idx], cfg_field, cfg_val, cfg_care);
      end
    end
  end

  // decode the raw bus cycle into the stored format
  always_comb begin
    io_exec  = (bus_io_transfer_cycle | bus_io_transfer_variant_cycle) & ~bus_fetch;
    cyc_next = '0;
    cyc_next.data      = bus_data;
    cyc_next.addr_phys = bus_addr_phys;
    cyc_next.bank      = bus_bank;
    cyc_next.ctrl[CB_IO]    = io_exec;
    cyc_next.ctrl[CB_WRITE] = bus_write & ~bus_fetch;
    cyc_next.ctrl[CB_CPU]   = bus_cpu;
    // dma cycles carry no cpu context, so those fields stay zero
    if (bus_cpu) begin
      cyc_next.addr_log        = bus_addr_log;
      cyc_next.table_nr        = bus_table_nr;
      cyc_next.level           = bus_level;
      cyc_next.ctrl[CB_FETCH]  = bus_fetch;
      cyc_next.ctrl[CB_ALT]    = bus_alternate_page_table & ~bus_fetch;
      cyc_next.ctrl[CB_INTR]   = bus_interrupts_enabled;
      cyc_next.ctrl[CB_PAGING] = bus_paging_enabled;
    end else begin
      cyc_next.addr_log = '0;
    end
    // io transfers compare on the device number only
    if (io_exec) begin
      cyc_next.addr_phys = ADDR_W'(bus_addr_log[DEV_W-1:0]);
      cyc_next.addr_log  = ADDR_W'(bus_addr_log[DEV_W-1:0]);
      cyc_next.bank      = '0;
    end
  end

  // one pipeline stage keeps the comparators off the bus input paths
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      cyc_reg       <= '0;
      cyc_valid_reg <= 1'b0;
    end else begin
      cyc_reg       <= cyc_next;
      cyc_valid_reg <= bus_valid;
    end
  end

  assign cyc_bus.valid = cyc_valid_reg;
  assign cyc_bus.ent   = cyc_reg;

  generate
    for (genvar g = 0; g < NUM_TRIG; g++) begin : g_trig
      tt_word_match u_match (
        .cyc (cyc_bus),
        .sel (trig_sel_reg[g]),
        .hit (trig_hit[g])
      );
    end
    for (genvar g = 0; g < NUM_QUAL; g++) begin : g_qual
      tt_word_match u_match (
        .cyc (cyc_bus),
        .sel (qual_sel_reg[g]),
        .hit (qual_hit[g])
      );
    end
  endgenerate

  // stop edge, taken from the raw cpu_stopped input one cycle ahead of the cycle pipeline
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      stopped_reg <= 1'b0;
    end else begin
      stopped_reg <= cpu_stopped;
    end
  end

  always_comb begin
    stop_rise = cpu_stopped & ~stopped_reg;
    trig_any  = (|(trig_hit & trig_word_en)) | (trig_on_stop_reg & stop_rise);
    arm_hit   = qual_hit[0];
    // in arm mode word 0 is the arm word and does not qualify
    if (arm_reg) begin
      qual_any = |(qual_hit[NUM_QUAL-1:1] & qual_word_en[NUM_QUAL-1:1]);
    end else begin
      qual_any = |(qual_hit & qual_word_en);
    end
    capturing = (state_reg == ST_RUN) || (state_reg == ST_POST);
    qual_wr   = capturing & qual_any;
    // abort or restart in the same cycle wins, so a trace aborted before its trigger never shows one
    trig_fire = (state_reg == ST_RUN) & trig_any & ~trace_abort & ~trace_start;
  end

  always_comb begin
    state_next = state_reg;
    if (trace_start) begin
      state_next = ST_CLEAR;
    end else begin
      unique case (state_reg)
        ST_IDLE, ST_DONE, ST_ABORT: state_next = state_reg;
        ST_CLEAR: begin
          if (trace_abort) begin
            state_next = ST_ABORT;
          end else if (clr_ptr_reg == POS_LAST) begin
            state_next = arm_reg ? ST_ARM : ST_RUN;
          end
        end
        ST_ARM: begin
          if (trace_abort) begin
            state_next = ST_ABORT;
          end else if (arm_hit) begin
            state_next = ST_RUN;
          end
        end
        ST_RUN: begin
          if (trace_abort) begin
            state_next = ST_ABORT;
          end else if (trig_fire) begin
            state_next = (post_init_reg == '0) ? ST_DONE : ST_POST;
          end
        end
        ST_POST: begin
          if (trace_abort) begin
            state_next = ST_ABORT;
          end else if (qual_wr && post_left_reg == PTR_ONE) begin
            state_next = ST_DONE;
          end
        end
        default: state_next = ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // status flags mirror the next state so they leave a flop
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_clearing  <= 1'b0;
      st_wait_arm  <= 1'b0;
      st_wait_trig <= 1'b0;
      st_post_trig <= 1'b0;
      st_trig_done <= 1'b0;
      st_aborted   <= 1'b0;
    end else begin
      st_clearing  <= state_next == ST_CLEAR;
      st_wait_arm  <= state_next == ST_ARM;
      st_wait_trig <= state_next == ST_RUN;
      st_post_trig <= state_next == ST_POST;
      st_trig_done <= state_next == ST_DONE;
      st_aborted   <= state_next == ST_ABORT;
    end
  end

  // options are latched at start so mid-trace changes are ignored
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      arm_reg          <= 1'b0;
      stop_on_trig_reg <= 1'b0;
      trig_on_stop_reg <= 1'b0;
      post_init_reg    <= '0;
    end else if (trace_start) begin
      arm_reg          <= arm_mode;
      stop_on_trig_reg <= stop_on_trig;
      trig_on_stop_reg <= trig_on_stop;
      post_init_reg    <= POS_LAST - trig_pos;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      clr_ptr_reg <= '0;
    end else if (trace_start) begin
      clr_ptr_reg <= '0;
    end else if (state_reg == ST_CLEAR) begin
      clr_ptr_reg <= clr_ptr_reg + PTR_ONE;
    end
  end

  // write pointer wraps, keeping the most recent cycles before trigger
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_ptr <= '0;
    end else if (trace_start) begin
      wr_ptr <= '0;
    end else if (qual_wr) begin
      wr_ptr <= wr_ptr + PTR_ONE;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      post_left_reg <= '0;
    end else if (trig_fire) begin
      post_left_reg <= post_init_reg;
    end else if (state_reg == ST_POST && qual_wr) begin
      post_left_reg <= post_left_reg - PTR_ONE;
    end
  end

  // trigger entry is the slot the triggering cycle would take
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      trig_seen <= 1'b0;
      trig_addr <= '0;
    end else if (trace_start) begin
      trig_seen <= 1'b0;
      trig_addr <= '0;
    end else if (trig_fire) begin
      trig_seen <= 1'b1;
      trig_addr <= wr_ptr;
    end
  end

  // stop request holds until the next start
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      stop_req <= 1'b0;
    end else if (trace_start) begin
      stop_req <= 1'b0;
    end else if (trig_fire && stop_on_trig_reg) begin
      stop_req <= 1'b1;
    end
  end

  // trace memory, no reset so it maps onto block ram
  always_ff @(posedge sys_clk) begin
    if (state_reg == ST_CLEAR) begin
      trace_mem[clr_ptr_reg] <= '0;
    end else if (qual_wr) begin
      trace_mem[wr_ptr] <= cyc_reg;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_data <= '0;
    end else begin
      rd_data <= trace_mem[rd_addr];
    end
  end
endmodule
`default_nettype wire

// file: tt_pkg.sv
// tt_pkg: constants and types shared by the bus trace trigger/capture logic
// Functional notes
// - control bit 7 only for executed io transfers
// - io cycles: address is 10-bit device number
// - control bit 6 is direction, fetch reads
// - control bit 5: 0 dma, 1 cpu
// - dma cycles: only data, direction, physical address
// - control bit 4: instruction fetch or data
// - control bit 3: normal or alternate table
// - control bit 2: interrupt system state
// - control bit 1: paging system state
// - level and table fields are enable masks
// - all five fields must match together
// - trigger is OR of enabled trigger words
// - all-zero level enables never match
// - qualification words gate trace memory writes
// - trigger and qualification evaluated independently
// - start clears trace memory before capture
// - stop request to cpu on trigger
// - cpu entering stop is extra trigger
// - trace memory holds 4096 entries
// - trigger position sets post-trigger cycle count
// - capture ends after post count or abort
// - status shows waiting for arm or trigger
// - arm mode: first qualifier word arms capture
// - logical mode: logical address and table fields
`default_nettype none
package tt_pkg;
  localparam int DATA_W      = 16;
  localparam int ADDR_W      = 16;
  localparam int BANK_W      = 8;
  localparam int CTRL_W      = 8;
  localparam int LEVEL_W     = 4;
  localparam int TABLE_W     = 2;
  localparam int DEV_W       = 10;
  localparam int NUM_WORDS   = 4;
  localparam int TRACE_DEPTH = 4096;
  // control bit positions; bit 0 is unused and reads zero
  localparam int CB_IO       = 7;
  localparam int CB_WRITE    = 6;
  localparam int CB_CPU      = 5;
  localparam int CB_FETCH    = 4;
  localparam int CB_ALT      = 3;
  localparam int CB_INTR     = 2;
  localparam int CB_PAGING   = 1;
  // select word field codes for the setup port
  localparam logic [2:0] FLD_DATA  = 3'h0;
  localparam logic [2:0] FLD_ADDR  = 3'h1;
  localparam logic [2:0] FLD_BANK  = 3'h2;
  localparam logic [2:0] FLD_CTRL  = 3'h3;
  localparam logic [2:0] FLD_LEVEL = 3'h4;
  localparam logic [2:0] FLD_TABLE = 3'h5;
  localparam logic [2:0] FLD_MODE  = 3'h6;
  typedef struct packed {
    logic [DATA_W-1:0]       data_val;
    logic [DATA_W-1:0]       data_care;
    logic [ADDR_W-1:0]       addr_val;
    logic [ADDR_W-1:0]       addr_care;
    logic [BANK_W-1:0]       bank_val;
    logic [BANK_W-1:0]       bank_care;
    logic [CTRL_W-1:0]       ctrl_val;
    logic [CTRL_W-1:0]       ctrl_care;
    logic [2**LEVEL_W-1:0]   level_en;
    logic [2**TABLE_W-1:0]   table_en;
    logic                    logical;
  } tt_sel_type;
  typedef struct packed {
    logic [DATA_W-1:0]  data;
    logic [ADDR_W-1:0]  addr_phys;
    logic [BANK_W-1:0]  bank;
    logic [ADDR_W-1:0]  addr_log;
    logic [TABLE_W-1:0] table_nr;
    logic [CTRL_W-1:0]  ctrl;
    logic [LEVEL_W-1:0] level;
  } tt_entry_type;
  typedef enum logic [6:0] {
    ST_IDLE  = 7'h01,
    ST_CLEAR = 7'h02,
    ST_ARM   = 7'h04,
    ST_RUN   = 7'h08,
    ST_POST  = 7'h10,
    ST_DONE  = 7'h20,
    ST_ABORT = 7'h40
  } tt_state_type;
endpackage
`default_nettype wire

// file: tt_cyc_if.sv
// tt_cyc_if: one decoded bus cycle handed to the select word comparators
`timescale 1ns/1ps
`default_nettype none
interface tt_cyc_if;
  import tt_pkg::*;
  logic         valid;
  tt_entry_type ent;
  modport src  (output valid, output ent);
  modport sink (input valid, input ent);
endinterface
`default_nettype wire

// file: tt_word_match.sv
// tt_word_match: compares one decoded bus cycle against one select word
`timescale 1ns/1ps
`default_nettype none
module tt_word_match
  import tt_pkg::*;
(
  // decoded cycle
  tt_cyc_if.sink          cyc,
  // select word
  input  wire tt_sel_type sel,
  // result
  output logic            hit
);
  logic data_ok;
  logic addr_ok;
  logic bank_ok;
  logic ctrl_ok;
  logic level_ok;

  always_comb begin
    // masked compare, a cleared care bit is a don't-care
    data_ok = ((cyc.ent.data ^ sel.data_val) & sel.data_care) == '0;
    if (sel.logical) begin
      addr_ok = ((cyc.ent.addr_log ^ sel.addr_val) & sel.addr_care) == '0;
      bank_ok = sel.table_en[cyc.ent.table_nr];
    end else begin
      addr_ok = ((cyc.ent.addr_phys ^ sel.addr_val) & sel.addr_care) == '0;
      bank_ok = ((cyc.ent.bank ^ sel.bank_val) & sel.bank_care) == '0;
    end
    ctrl_ok  = ((cyc.ent.ctrl ^ sel.ctrl_val) & sel.ctrl_care) == '0;
    // no level bit set means this word can never hit
    level_ok = sel.level_en[cyc.ent.level];
    hit      = cyc.valid & data_ok & addr_ok & bank_ok & ctrl_ok & level_ok;
  end
endmodule
`default_nettype wire

// file: tt_tracer_properties.sv
// tt_tracer_properties: concurrent checks on the tracer's top-level ports
`timescale 1ns/1ps
`default_nettype none
module tt_tracer_properties
  import tt_pkg::*;
#(
  parameter int  NUM_TRIG = NUM_WORDS,
  parameter int  NUM_QUAL = NUM_WORDS,
  parameter int  DEPTH    = TRACE_DEPTH,
  localparam int PW       = $clog2(DEPTH)
)(
  // clock and reset
  input wire logic          sys_clk,
  input wire logic          rst_b,
  // trace control
  input wire logic          trace_start,
  input wire logic          trace_abort,
  // status
  input wire logic          st_clearing,
  input wire logic          st_wait_arm,
  input wire logic          st_wait_trig,
  input wire logic          st_post_trig,
  input wire logic          st_trig_done,
  input wire logic          st_aborted,
  input wire logic          stop_req,
  input wire logic          trig_seen,
  input wire logic [PW-1:0] trig_addr,
  input wire logic [PW-1:0] wr_ptr
);
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (!rst_b);

  chk_start_clears: assert property (trace_start |=> st_clearing)
    else $error("start did not begin clearing");
  // past reset guard: the first edge after release still sees the reset values
  chk_clear_ends: assert property ($past(rst_b) && $fell(st_clearing) |-> st_wait_arm || st_wait_trig || st_aborted)
    else $error("clearing ended in a wrong state");
  chk_stop_cause: assert property ($rose(stop_req) |-> $rose(trig_seen))
    else $error("stop request without a trigger");
  chk_trig_slot: assert property ($rose(trig_seen) |-> trig_addr == $past(wr_ptr))
    else $error("trigger slot not the write slot");
  chk_trig_next: assert property ($rose(trig_seen) |-> st_post_trig || st_trig_done)
    else $error("trigger did not leave the waiting state");
  chk_done_frozen: assert property ((st_trig_done || st_aborted) && !trace_start |=> $stable(wr_ptr))
    else $error("capture went on after the end");
  chk_ptr_step: assert property (st_wait_trig && $past(st_wait_trig) && $changed(wr_ptr)
    |-> wr_ptr == PW'($past(wr_ptr) + 1'b1))
    else $error("write slot did not step by one");
  chk_abort_stops: assert property (trace_abort && !trace_start
    && (st_clearing || st_wait_arm || st_wait_trig || st_post_trig) |=> st_aborted)
    else $error("abort not honoured");
  chk_state_onehot: assert property ($onehot0({st_clearing, st_wait_arm, st_wait_trig,
    st_post_trig, st_trig_done, st_aborted}))
    else $error("status not one-hot");
endmodule
`default_nettype wire

// file: tt_bus_model.sv
// tt_bus_model: backplane side that presents bus cycles and the cpu stop line
`timescale 1ns/1ps
`default_nettype none
module tt_bus_model
  import tt_pkg::*;
(
  // clock
  input  wire logic          sys_clk,
  // bus cycle
  output logic               bus_valid,
  output logic [DATA_W-1:0]  bus_data,
  output logic [ADDR_W-1:0]  bus_addr,
  output logic [BANK_W-1:0]  bus_bank,
  output logic [LEVEL_W-1:0] bus_level,
  output logic [7:0]         bus_kind,
  // cpu state
  output logic               cpu_stopped
);
  initial begin
    {bus_valid, bus_data, bus_addr, bus_bank, bus_level, bus_kind, cpu_stopped} = '0;
  end
  // one cycle per call; released lines show the inverse, so a stale copy cannot match
  task automatic issue(input logic [15:0] d, input logic [15:0] a, input logic [7:0] b, input logic [7:0] k);
    @(posedge sys_clk);
    bus_valid <= 1'b1;
    {bus_data, bus_addr, bus_bank, bus_level, bus_kind} <= {d, a, b, d[3:0], k};
    @(posedge sys_clk);
    bus_valid <= 1'b0;
    {bus_data, bus_addr, bus_bank, bus_level, bus_kind} <= ~{d, a, b, d[3:0], k};
  endtask
  task automatic stop_cpu(input logic v);
    @(posedge sys_clk);
    cpu_stopped <= v;
  endtask
endmodule
`default_nettype wire

// file: test_tt_tracer.sv
// test_tt_tracer: directed bench for the bus trace trigger and capture block
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin n_fail++; \
  $display("mismatch %s expected %h seen %h", nm, ex, got); end end
module test_tt_tracer
  import tt_pkg::*;
;
  localparam int DP = 16;
  logic         sys_clk, rst_b, bus_valid, cpu_stopped, cfg_we, cfg_qual, trace_start, trace_abort;
  logic         arm_mode, stop_on_trig, trig_on_stop, stop_req, trig_seen;
  logic         st_clearing, st_wait_arm, st_wait_trig, st_post_trig, st_trig_done, st_aborted;
  logic [15:0]  bus_data, bus_addr, cfg_val, cfg_care;
  logic [7:0]   bus_bank, bus_kind;
  logic [3:0]   bus_level, trig_word_en, qual_word_en, trig_pos, rd_addr, trig_addr, wr_ptr;
  logic [2:0]   cfg_field;
  logic [1:0]   cfg_idx;
  tt_entry_type rd_data, ent;
  int           n_fail, check_count, i;
  // flags {io, io variant, fetch, write, cpu, alternate, interrupts, paging} and the control byte they give
  logic [7:0]   kinds [5] = '{8'h98, 8'hbb, 8'h4c, 8'h16, 8'h08};
  logic [7:0]   ctrls [5] = '{8'he0, 8'h36, 8'ha8, 8'h40, 8'h20};

  tt_tracer #(.NUM_TRIG(4), .NUM_QUAL(4), .DEPTH(DP)) i_tt_tracer (
    .sys_clk(sys_clk), .rst_b(rst_b), .bus_valid(bus_valid), .bus_data(bus_data), .bus_addr_phys(bus_addr),
    .bus_bank(bus_bank), .bus_addr_log(bus_addr), .bus_table_nr(bus_level[1:0]), .bus_level(bus_level),
    .bus_io_transfer_cycle(bus_kind[7]), .bus_io_transfer_variant_cycle(bus_kind[6]), .bus_fetch(bus_kind[5]),
    .bus_write(bus_kind[4]), .bus_cpu(bus_kind[3]), .bus_alternate_page_table(bus_kind[2]),
    .bus_interrupts_enabled(bus_kind[1]), .bus_paging_enabled(bus_kind[0]), .cpu_stopped(cpu_stopped),
    .cfg_we(cfg_we), .cfg_qual(cfg_qual), .cfg_idx(cfg_idx), .cfg_field(cfg_field), .cfg_val(cfg_val),
    .cfg_care(cfg_care), .trig_word_en(trig_word_en), .qual_word_en(qual_word_en), .trace_start(trace_start),
    .trace_abort(trace_abort), .arm_mode(arm_mode), .stop_on_trig(stop_on_trig), .trig_on_stop(trig_on_stop),
    .trig_pos(trig_pos), .st_clearing(st_clearing), .st_wait_arm(st_wait_arm), .st_wait_trig(st_wait_trig),
    .st_post_trig(st_post_trig), .st_trig_done(st_trig_done), .st_aborted(st_aborted), .stop_req(stop_req),
    .trig_seen(trig_seen), .trig_addr(trig_addr), .wr_ptr(wr_ptr), .rd_addr(rd_addr), .rd_data(rd_data));
  tt_bus_model i_tt_bus_model (.sys_clk(sys_clk), .bus_valid(bus_valid), .bus_data(bus_data), .bus_addr(bus_addr),
    .bus_bank(bus_bank), .bus_level(bus_level), .bus_kind(bus_kind), .cpu_stopped(cpu_stopped));

  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic set_field(input logic q, input logic [1:0] w, input logic [2:0] f, input logic [15:0] v, c);
    @(posedge sys_clk);
    {cfg_we, cfg_qual, cfg_idx, cfg_field, cfg_val, cfg_care} <= {1'b1, q, w, f, v, c};
    @(posedge sys_clk);
    cfg_we <= 1'b0;
  endtask
  // options ride with the start pulse; the clear pass is waited out under a bound
  task automatic begin_trace(input logic a, s, t, input logic [3:0] p);
    int n;
    @(posedge sys_clk);
    {trace_start, arm_mode, stop_on_trig, trig_on_stop, trig_pos} <= {1'b1, a, s, t, p};
    @(posedge sys_clk);
    trace_start <= 1'b0;
    #1;
    `CHK("clearing", 1'b1, st_clearing)
    for (n = 0; n < 40 && st_clearing !== 1'b0; n++) @(posedge sys_clk) #1;
    if (n >= 40) begin
      n_fail++;
      complete_run();
    end
  endtask
  task automatic settle();
    repeat (3) @(posedge sys_clk);
    #1;
  endtask
  task automatic read_entry(input logic [3:0] a);
    @(posedge sys_clk);
    rd_addr <= a;
    repeat (2) @(posedge sys_clk);
    #1;
    ent = rd_data;
  endtask

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  initial begin
    {rst_b, cfg_we, cfg_qual, trace_start, trace_abort, arm_mode, stop_on_trig, trig_on_stop} = '0;
    {cfg_idx, cfg_field, cfg_val, cfg_care, trig_pos, rd_addr, n_fail, check_count} = '0;
    trig_word_en = 4'hf;
    qual_word_en = 4'h1;
    repeat (2) @(posedge sys_clk);
    rst_b <= 1'b1;
    // flag decode, io device number, two cycles kept after the trigger; trigger word 1 is left with no levels
    set_field(1'b1, 2'h0, FLD_LEVEL, 16'hffff, 16'hffff);
    set_field(1'b0, 2'h0, FLD_LEVEL, 16'hffff, 16'hffff);
    set_field(1'b0, 2'h0, FLD_DATA, 16'h1234, 16'hffff);
    begin_trace(1'b0, 1'b0, 1'b0, 4'hd);
    for (i = 0; i < 5; i++) i_tt_bus_model.issue(i < 4 ? 16'h0100 + 16'(i) : 16'h1234, 16'hfc05, 8'h00, kinds[i]);
    settle();
    `CHK("post state", 1'b1, st_post_trig)
    `CHK("trigger slot", 4'h4, trig_addr)
    `CHK("stop unset", 1'b0, stop_req)
    repeat (3) i_tt_bus_model.issue(16'h0200, 16'h0040, 8'h00, 8'h08);
    settle();
    `CHK("done", 1'b1, st_trig_done)
    `CHK("stored", 4'h7, wr_ptr)
    for (i = 0; i < 5; i++) begin
      read_entry(4'(i));
      `CHK("ctrl", ctrls[i], ent.ctrl)
    end
    read_entry(4'h0);
    `CHK("device nr", 16'h0005, ent.addr_phys)
    `CHK("io data", 16'h0100, ent.data)
    $display("test decode finished");
    // all fields must match; the triggering cycle fails qualification and is not kept
    set_field(1'b0, 2'h2, FLD_LEVEL, 16'hffff, 16'hffff);
    set_field(1'b0, 2'h2, FLD_DATA, 16'h5555, 16'h7fff);
    set_field(1'b0, 2'h2, FLD_BANK, 16'h0007, 16'h00ff);
    set_field(1'b1, 2'h0, FLD_DATA, 16'h0000, 16'h8000);
    set_field(1'b0, 2'h3, FLD_LEVEL, 16'hffff, 16'hffff);
    set_field(1'b0, 2'h3, FLD_MODE, 16'h0001, 16'h0000);
    set_field(1'b0, 2'h3, FLD_TABLE, 16'h0008, 16'h0000);
    begin_trace(1'b0, 1'b1, 1'b0, 4'hf);
    i_tt_bus_model.issue(16'h5555, 16'h0010, 8'h00, 8'h08);
    i_tt_bus_model.issue(16'hd555, 16'h0010, 8'h07, 8'h08);
    settle();
    `CHK("done", 1'b1, st_trig_done)
    `CHK("trigger slot", 4'h1, trig_addr)
    `CHK("stored", 4'h1, wr_ptr)
    `CHK("stop", 1'b1, stop_req)
    $display("test match finished");
    // arm word gates everything, then the cpu stopping triggers
    begin_trace(1'b1, 1'b0, 1'b1, 4'hf);
    `CHK("stop cleared", 1'b0, stop_req)
    i_tt_bus_model.issue(16'h8000, 16'h0010, 8'h00, 8'h08);
    settle();
    `CHK("wait arm", 1'b1, st_wait_arm)
    i_tt_bus_model.issue(16'h0001, 16'h0010, 8'h00, 8'h08);
    settle();
    `CHK("wait trig", 1'b1, st_wait_trig)
    `CHK("arm unstored", 4'h0, wr_ptr)
    i_tt_bus_model.stop_cpu(1'b1);
    settle();
    `CHK("stop trigger", 1'b1, st_trig_done)
    i_tt_bus_model.stop_cpu(1'b0);
    read_entry(4'h0);
    `CHK("cleared", 70'h0, ent)
    $display("test arm finished");
    // abort before any trigger; a matching cycle afterwards changes nothing
    begin_trace(1'b0, 1'b0, 1'b0, 4'h0);
    i_tt_bus_model.issue(16'h0002, 16'h0010, 8'h00, 8'h08);
    @(posedge sys_clk);
    trace_abort <= 1'b1;
    @(posedge sys_clk);
    trace_abort <= 1'b0;
    i_tt_bus_model.issue(16'h1234, 16'h0010, 8'h00, 8'h08);
    settle();
    `CHK("aborted", 1'b1, st_aborted)
    `CHK("no trigger", 1'b0, trig_seen)
    `CHK("stored", 4'h1, wr_ptr)
    $display("test abort finished");
    complete_run();
  end
endmodule
bind tt_tracer tt_tracer_properties #(.NUM_TRIG(NUM_TRIG), .NUM_QUAL(NUM_QUAL), .DEPTH(DEPTH)) i_tt_tracer_properties (
  .sys_clk(sys_clk), .rst_b(rst_b), .trace_start(trace_start), .trace_abort(trace_abort),
  .st_clearing(st_clearing), .st_wait_arm(st_wait_arm), .st_wait_trig(st_wait_trig), .st_post_trig(st_post_trig),
  .st_trig_done(st_trig_done), .st_aborted(st_aborted), .stop_req(stop_req), .trig_seen(trig_seen),
  .trig_addr(trig_addr), .wr_ptr(wr_ptr));
`default_nettype wire
